/* File: bench/csbl_disk_model.sv */
`timescale 1ns/1ps
module csbl_disk_model (
  // Clock and bench control
  input wire logic clock_i,
  input wire logic load_init_i,
  input wire logic slow_i,
  input wire logic [15:0] word_i,
  input wire logic [15:0] count_i,
  input wire logic restart_i,
  input wire logic inhibit_i,
  // Adapter pins
  output logic strobe_n_o,
  output logic [15:0] data_o,
  output logic restart_n_o,
  output logic restart_inh_n_o,
  output logic taken_o
);
  int sent = 0;

  initial begin
    strobe_n_o = 1'b1;
    data_o = 16'h0000;
    restart_n_o = 1'b1;
    restart_inh_n_o = 1'b1;
    taken_o = 1'b0;
  end

  // ***************
  // Word stream
  // ***************
  always begin
    @(posedge clock_i);
    if (load_init_i !== 1'b1) begin
      sent = 0;
    end else if (sent < int'(count_i)) begin
      strobe_n_o <= 1'b0;
      data_o <= word_i;
      taken_o <= 1'b1;
      sent = sent + 1;
      @(posedge clock_i);
      taken_o <= 1'b0;
      repeat (slow_i ? 4 : 2) @(posedge clock_i);
      strobe_n_o <= 1'b1;
      // Released lines flip so a stale word cannot pass
      data_o <= ~data_o;
      repeat (slow_i ? 6 : 2) @(posedge clock_i);
    end
  end

  // Inhibit wraps the restart by one cycle each side
  always begin
    @(posedge clock_i);
    if (restart_i) begin
      restart_inh_n_o <= !inhibit_i;
      @(posedge clock_i);
      restart_n_o <= 1'b0;
      repeat (3) @(posedge clock_i);
      restart_n_o <= 1'b1;
      @(posedge clock_i);
      restart_inh_n_o <= 1'b1;
    end
  end
endmodule

/* File: bench/csbl_loader_tb.sv */
`timescale 1ns/1ps
module csbl_loader_tb
  import csbl_pkg::*;
;
  logic clock_i = 1'b0;
  logic rstn_i, power_reset_i, load_switch_i, load_select_i, maint_switch_i, console_state_i;
  logic strobe_n_i, restart_n_i, restart_inh_n_i, alt_end_n_i, sys_reset_o, load_init_o;
  logic primary_source_o, maint_out_o, load_complete_o, cs_write_sel_o, console_stop_o;
  logic console_run_o, slow, restart, inhibit, taken;
  logic prev_cs = 1'b0, prev_rst = 1'b0, prev_init = 1'b0, prev_cmp = 1'b0;
  logic [15:0] data_i, console_data_o, word, cnt;
  logic [15:0] run_q[$], wr_q[$];
  logic [31:0] rdata_o;
  csbl_bus_s bus_i;
  csbl_cswr_s cs_wr_o;
  int fail_count = 0, tests_run = 0, seed = 80, cyc = 0, widx = 0, total = 0, cs_lim = 0;
  int nl_cyc = 0, l_cyc = 0, hi_len = 0, rst_len = 0, fall_cyc = 0;

  always #50 clock_i = ~clock_i;

  csbl_loader uut (.clock_i, .rstn_i, .bus_i, .rdata_o, .power_reset_i, .load_switch_i,
    .load_select_i, .maint_switch_i, .console_state_i, .strobe_n_i, .data_i, .restart_n_i,
    .restart_inh_n_i, .alt_end_n_i, .sys_reset_o, .load_init_o, .primary_source_o,
    .maint_out_o, .load_complete_o, .cs_write_sel_o, .console_stop_o, .console_run_o,
    .console_data_o, .cs_wr_o);

  csbl_disk_model adapter (.clock_i, .load_init_i(load_init_o), .slow_i(slow), .word_i(word),
    .count_i(cnt), .restart_i(restart), .inhibit_i(inhibit), .strobe_n_o(strobe_n_i),
    .data_o(data_i), .restart_n_o(restart_n_i), .restart_inh_n_o(restart_inh_n_i),
    .taken_o(taken));

  // Console stalls kept rare so no strobe lands on a pending word
  always @(posedge clock_i) begin
    console_state_i <= ($random(seed) & 15) != 0;
    slow <= 1'($random(seed));
    word <= 16'($random(seed));
  end

  // ***************
  // Bench tasks
  // ***************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    bus_i <= '0;
    @(posedge clock_i);
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    @(negedge clock_i);
    check("rdata", rdata_o, exp);
    @(posedge clock_i);
  endtask

  task automatic wait_init(input logic level, input int limit);
    int n;
    n = 0;
    while (load_init_o !== level) begin
      @(posedge clock_i);
      n++;
      if (n > limit) begin
        check("wait bound", 1'b0, 1'b1);
        report_and_stop();
      end
    end
  endtask

  task automatic run_load(input int cs, input int tot);
    cs_lim = cs;
    total = tot;
    widx = 0;
    run_q.delete();
    wr_q.delete();
    cnt <= 16'(tot);
    wait_init(1'b1, 5000);
    wait_init(1'b0, 60000);
    check("words", widx, tot);
    check("runs", run_q.size(), 0);
    rd_reg(REG_COUNT, 32'(tot));
  endtask

  task automatic pulse_restart(input logic inh);
    inhibit <= inh;
    restart <= 1'b1;
    @(posedge clock_i);
    restart <= 1'b0;
    repeat (12) @(negedge clock_i);
  endtask

  // ***************
  // Monitor
  // ***************
  always @(negedge clock_i) begin
    cyc++;
    if (taken) begin
      run_q.push_back(data_i);
      wr_q.push_back(data_i);
    end
    if (console_run_o) check("cdata", console_data_o, run_q.pop_front());
    if (cs_wr_o.strobe) begin
      check("wslot", prev_cs, 1'b1);
      check("wdata", cs_wr_o.data, wr_q.pop_front());
      check("atsel", cs_wr_o.at_sel, widx >= cs_lim);
      if (widx < cs_lim) check("waddr", cs_wr_o.addr, widx);
      else check("taddr", cs_wr_o.addr, widx - cs_lim);
      widx++;
      if (widx == total - 1) nl_cyc = cyc;
      if (widx == total) l_cyc = cyc;
    end
    if (load_complete_o && !prev_cmp) check("rise", (cyc - nl_cyc) inside {[10:20]}, 1);
    if (!load_complete_o && prev_cmp) begin
      check("width", hi_len >= 30, 1'b1);
      check("fall", (cyc - l_cyc) >= 10, 1'b1);
      check("endinit", load_init_o, 1'b0);
    end
    hi_len = load_complete_o ? hi_len + 1 : 0;
    if (sys_reset_o) rst_len++;
    if (!sys_reset_o && prev_rst) begin
      check("rstlen", rst_len inside {[4000:6000]}, 1'b1);
      rst_len = 0;
      fall_cyc = cyc;
    end
    if (load_init_o && !prev_init) check("pause", (cyc - fall_cyc) inside {[25:35]}, 1);
    check("stop", console_stop_o, load_init_o);
    check("wsel", cs_write_sel_o, load_init_o & ~maint_out_o);
    prev_cs = console_state_i;
    prev_rst = sys_reset_o;
    prev_init = load_init_o;
    prev_cmp = load_complete_o;
  end

  initial begin
    rstn_i = 1'b0;
    bus_i = '0;
    power_reset_i = 1'b1;
    load_switch_i = 1'b0;
    load_select_i = 1'b1;
    maint_switch_i = 1'b0;
    console_state_i = 1'b1;
    alt_end_n_i = 1'b1;
    slow = 1'b0;
    word = 16'h0000;
    cnt = 16'h0000;
    restart = 1'b0;
    inhibit = 1'b0;
    repeat (20) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    rd_reg(REG_CTRL, 32'h0000_4100);
    rd_reg(REG_STATUS, 32'h0000_0010);
    wr_reg(REG_STATUS, 32'hffff_ffff);
    rd_reg(4'hc, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_1010);
    rd_reg(REG_CTRL, 32'h0000_1010);
    power_reset_i <= 1'b0;
    run_load(1024, 1280);
    wr_reg(REG_CTRL, 32'h0000_4101);
    cnt <= 16'h0000;
    load_switch_i <= 1'b1;
    wait_init(1'b1, 5000);
    maint_switch_i <= 1'b1;
    repeat (6) @(negedge clock_i);
    check("maint", maint_out_o, 1'b1);
    @(posedge clock_i);
    maint_switch_i <= 1'b0;
    pulse_restart(1'b1);
    check("inhibit", load_init_o, 1'b1);
    @(posedge clock_i);
    pulse_restart(1'b0);
    check("restart", sys_reset_o, 1'b1);
    check("rstend", load_init_o, 1'b0);
    @(posedge clock_i);
    run_load(4096, 4352);
    cnt <= 16'h0000;
    load_switch_i <= 1'b0;
    load_select_i <= 1'b0;
    repeat (6) @(negedge clock_i);
    check("primary", primary_source_o, 1'b0);
    @(posedge clock_i);
    load_switch_i <= 1'b1;
    wait_init(1'b1, 5000);
    alt_end_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    alt_end_n_i <= 1'b1;
    repeat (8) @(negedge clock_i);
    check("altend", load_init_o, 1'b0);
    report_and_stop();
  end
endmodule

/* File: src/csbl_loader.sv */
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
// Overview of operation
// R01: Boot load starts on power reset release, load switch, or adapter restart.
// R02: First step holds system reset between 0.4 and 0.6 ms.
// R03: After system reset, pause 2.5 to 3.5 us for adapter settling.
// R04: Load flip-flop forces load initiate, control store write and console stop.
// R05: Forced control store write is blocked in maintenance mode.
// R06: Selected adapter sends boot words with strobes once load initiate rises.
// R07: Words fill control store first, then the address table.
// R08: Minimum size select limits load to 4096 plus 256 words.
// R09: Load ends on primary end, alternate end, or any system reset.
// R10: Load initiate is high exactly while the load flip-flop is set.
// R11: Adapter holds 16 data lines valid during its active-low strobe.
// R12: Each strobe captures data into console register and issues console run; a strobe on a stalled pending word or past the load size is dropped.
// R13: Primary source level follows the load select switch.
// R14: Maintenance output is high while the console is in maintenance mode.
// R15: Adapter restart pulse restarts the load unless inhibited.
// R16: Restart inhibit pulse around the restart makes the device ignore it.
// R17: Load complete rises after next-to-last word, falls after last, high 3 us.
// R18: Hardware control store writes occur only in console state.
// R19: Alternate adapter signals finish with active-low pulse of at least 50 ns.
// R20: Each asynchronous adapter pulse is synchronised and acted on once.
module csbl_loader
  import csbl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Register port
  input wire csbl_bus_s bus_i,
  output logic [31:0] rdata_o,
  // Switches and processor state
  input wire logic power_reset_i,
  input wire logic load_switch_i,
  input wire logic load_select_i,
  input wire logic maint_switch_i,
  input wire logic console_state_i,
  // Adapters
  input wire logic strobe_n_i,
  input wire logic [15:0] data_i,
  input wire logic restart_n_i,
  input wire logic restart_inh_n_i,
  input wire logic alt_end_n_i,
  // Loader outputs
  output logic sys_reset_o,
  output logic load_init_o,
  output logic primary_source_o,
  output logic maint_out_o,
  output logic load_complete_o,
  output logic cs_write_sel_o,
  output logic console_stop_o,
  output logic console_run_o,
  output logic [15:0] console_data_o,
  output csbl_cswr_s cs_wr_o
);

  // ***********************************
  // Input synchronisers
  // ***********************************
  logic [20:0] lvl_s;
  logic [15:0] data_s;
  logic por_s;
  logic sw_s;
  logic prim_s;
  logic maint_s;
  logic inh_n_s;
  logic stb_pulse;
  logic rs_pulse;
  logic alt_pulse;

  csbl_sync #(
    .W(21)
  ) u_lvl (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i({data_i, power_reset_i, load_switch_i, load_select_i, maint_switch_i,
              restart_inh_n_i}),
    .sync_o(lvl_s)
  );

  assign data_s = lvl_s[20:5];
  assign por_s = lvl_s[4];
  assign sw_s = lvl_s[3];
  assign prim_s = lvl_s[2];
  assign maint_s = lvl_s[1];
  assign inh_n_s = lvl_s[0];

  csbl_pulse u_stb (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pulse_n_i(strobe_n_i),
    .level_n_o(),
    .pulse_o(stb_pulse)
  );

  csbl_pulse u_rs (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pulse_n_i(restart_n_i),
    .level_n_o(),
    .pulse_o(rs_pulse)
  );

  csbl_pulse u_alt (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .pulse_n_i(alt_end_n_i),
    .level_n_o(),
    .pulse_o(alt_pulse)
  );

  // ***********************************
  // Sequencer
  // ***********************************
  csbl_main_s main_ff;
  csbl_main_s nxt_main;
  logic [14:0] cs_lim;
  logic [14:0] at_lim;
  logic [14:0] total;
  logic [14:0] cnt_inc;
  logic start_ev;
  logic end_drop;
  logic in_load;

  assign in_load = (main_ff.state == ST_LOAD);

  always_comb begin
    nxt_main = main_ff;
    nxt_main.run = 1'b0;
    nxt_main.wr.strobe = 1'b0;
    nxt_main.por_prev = por_s;
    nxt_main.sw_prev = sw_s;
    end_drop = 1'b0;
    cnt_inc = main_ff.cnt + 15'h0001;
    // Installed sizes, overridden by minimum select
    cs_lim = main_ff.min_sel ? CS_MIN_WORDS : {main_ff.csb, 10'h000}; // [R07] [R08]
    at_lim = main_ff.min_sel ? AT_MIN_WORDS : {4'h0, main_ff.atb, 8'h00}; // [R07] [R08]
    total = cs_lim + at_lim;
    // Restart honoured only with inhibit released [R15] [R16]
    start_ev = (main_ff.por_prev & ~por_s) | (sw_s & ~main_ff.sw_prev) |
               (rs_pulse & inh_n_s); // [R01]

    unique case (main_ff.state)
      ST_IDLE: begin
      end
      ST_RESET: begin
        if (main_ff.tmr == SYSRST_LAST) begin // [R02]
          nxt_main.state = ST_PAUSE;
          nxt_main.tmr = 13'h0000;
        end else begin
          nxt_main.tmr = main_ff.tmr + 13'h0001;
        end
      end
      ST_PAUSE: begin
        if (main_ff.tmr == PAUSE_LAST) begin // [R03]
          nxt_main.state = ST_LOAD; // [R04]
          nxt_main.tmr = 13'h0000;
        end else begin
          nxt_main.tmr = main_ff.tmr + 13'h0001;
        end
      end
      ST_LOAD: begin
        // Write held until console state, never during microcommands
        if (main_ff.pend && console_state_i) begin // [R18]
          nxt_main.pend = 1'b0;
          nxt_main.wr.strobe = 1'b1;
          nxt_main.wr.data = main_ff.data;
          nxt_main.cnt = cnt_inc;
          if (main_ff.cnt < cs_lim) begin // [R07]
            nxt_main.wr.at_sel = 1'b0;
            nxt_main.wr.addr = main_ff.cnt[13:0];
          end else begin
            nxt_main.wr.at_sel = 1'b1;
            nxt_main.wr.addr = 14'(main_ff.cnt - cs_lim);
          end
          if (cnt_inc == total - 15'h0001) begin // [R17]
            nxt_main.e_arm = 1'b1;
            nxt_main.e_tmr = 6'h00;
          end
          if (cnt_inc == total) begin
            nxt_main.e_last = 1'b1;
            nxt_main.l_tmr = 6'h00;
          end
        end
        // Words beyond the installed size are dropped
        if (stb_pulse && (!main_ff.pend || console_state_i) &&
            (main_ff.cnt + {14'h0000, main_ff.pend} < total)) begin
          nxt_main.pend = 1'b1;
          nxt_main.data = data_s; // [R12]
          nxt_main.run = 1'b1; // [R12]
        end
      end
    endcase

    // Load complete pulse
    if (main_ff.e_arm) begin
      if (main_ff.e_tmr == END_DLY_LAST) begin // [R17]
        nxt_main.e_arm = 1'b0;
        nxt_main.e_out = 1'b1;
        nxt_main.e_tmr = 6'h00;
      end else begin
        nxt_main.e_tmr = main_ff.e_tmr + 6'h01;
      end
    end else if (main_ff.e_out && main_ff.e_tmr != TMR_SAT) begin
      nxt_main.e_tmr = main_ff.e_tmr + 6'h01;
    end
    if (main_ff.e_last) begin
      if (main_ff.l_tmr != TMR_SAT) begin
        nxt_main.l_tmr = main_ff.l_tmr + 6'h01;
      end
      // Held on until both the 1 us delay and the 3 us width are met
      if (main_ff.l_tmr >= END_DLY_LAST && main_ff.e_out &&
          main_ff.e_tmr >= END_HIGH_LAST) begin // [R17]
        nxt_main.e_out = 1'b0;
        nxt_main.e_last = 1'b0;
        end_drop = 1'b1;
      end
    end

    // Termination
    if (in_load && ((end_drop && prim_s) || (alt_pulse && !prim_s))) begin // [R09]
      nxt_main.state = ST_IDLE;
      nxt_main.pend = 1'b0;
    end

    if (start_ev) begin
      nxt_main.state = ST_RESET; // [R01]
      nxt_main.tmr = 13'h0000;
      nxt_main.cnt = 15'h0000;
      nxt_main.pend = 1'b0;
      nxt_main.e_arm = 1'b0;
      nxt_main.e_out = 1'b0;
      nxt_main.e_last = 1'b0;
    end

    // Power reset held keeps the sequencer idle
    if (por_s) begin // [R09]
      nxt_main.state = ST_IDLE;
      nxt_main.pend = 1'b0;
      nxt_main.e_arm = 1'b0;
      nxt_main.e_out = 1'b0;
      nxt_main.e_last = 1'b0;
    end

    // ***********************************
    // Register port
    // ***********************************
    nxt_main.rdata = 32'h0000_0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        REG_CTRL: begin
          nxt_main.rdata[CTRL_MIN_BIT] = main_ff.min_sel;
          nxt_main.rdata[CTRL_CSB_LSB +: 5] = main_ff.csb;
          nxt_main.rdata[CTRL_ATB_LSB +: 3] = main_ff.atb;
        end
        REG_STATUS: begin
          nxt_main.rdata[STAT_STATE_LSB +: 2] = main_ff.state;
          nxt_main.rdata[STAT_LOAD_BIT] = in_load;
          nxt_main.rdata[STAT_END_BIT] = main_ff.e_out;
          nxt_main.rdata[STAT_PRIM_BIT] = prim_s;
          nxt_main.rdata[STAT_MAINT_BIT] = maint_s;
          nxt_main.rdata[STAT_PEND_BIT] = main_ff.pend;
        end
        REG_COUNT: begin
          nxt_main.rdata[14:0] = main_ff.cnt;
        end
        default: begin
        end
      endcase
    end
    if (bus_i.wr && bus_i.addr == REG_CTRL) begin
      nxt_main.min_sel = bus_i.wdata[CTRL_MIN_BIT]; // [R08]
      nxt_main.csb = bus_i.wdata[CTRL_CSB_LSB +: 5];
      nxt_main.atb = bus_i.wdata[CTRL_ATB_LSB +: 3];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      main_ff <= MAIN_RST;
    end else begin
      main_ff <= nxt_main;
    end
  end

  // ***********************************
  // Outputs
  // ***********************************
  assign sys_reset_o = (main_ff.state == ST_RESET); // [R02]
  assign load_init_o = in_load; // [R10]
  assign console_stop_o = in_load; // [R04]
  assign cs_write_sel_o = in_load & ~maint_s; // [R04] [R05]
  assign primary_source_o = prim_s; // [R13]
  assign maint_out_o = maint_s; // [R14]
  assign load_complete_o = main_ff.e_out; // [R17]
  assign console_run_o = main_ff.run;
  assign console_data_o = main_ff.data;
  assign cs_wr_o = main_ff.wr;
  assign rdata_o = main_ff.rdata;

  // ***********************************
  // Assertions
  // ***********************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  a_sysrst_width: assert property ( // [R02]
    (main_ff.state == ST_RESET && nxt_main.state == ST_PAUSE) |->
      main_ff.tmr == 13'h0f9f)
    else $error("system reset step not 4000 cycles");

  // Depth checks instead of a long repetition: reset fell exactly 25 cycles back
  a_pause_width: assert property ( // [R03]
    $rose(load_init_o) |-> $past(sys_reset_o, 26) && !$past(sys_reset_o, 25) &&
      !$past(load_init_o, 25))
    else $error("pause before load not 25 cycles");

  a_start_event: assert property ( // [R01]
    start_ev && !por_s |=> sys_reset_o && main_ff.tmr == 13'h0000)
    else $error("start event did not begin system reset");

  a_load_forces: assert property ( // [R04]
    load_init_o |-> console_stop_o && (cs_write_sel_o == !maint_out_o))
    else $error("load flip-flop does not force stop and write");

  a_maint_block: assert property ( // [R05]
    maint_out_o |-> !cs_write_sel_o)
    else $error("control store write forced in maintenance mode");

  a_strobe_run: assert property ( // [R12]
    stb_pulse && in_load && !main_ff.pend && main_ff.cnt < total && !start_ev && !por_s
      |=> console_run_o && console_data_o == $past(data_s))
    else $error("strobe did not capture data and run");

  a_write_console: assert property ( // [R18]
    $rose(cs_wr_o.strobe) |-> $past(console_state_i))
    else $error("control store written outside console state");

  a_end_rise: assert property ( // [R17]
    $rose(load_complete_o) |-> $past(main_ff.e_arm) && $past(main_ff.e_tmr) == 6'h09)
    else $error("load complete rose without 1 us delay");

  a_end_width: assert property ( // [R17]
    $fell(load_complete_o) && !$past(start_ev) && !$past(por_s) |->
      $past(main_ff.e_tmr) >= 6'h1d)
    else $error("load complete pulse shorter than 3 us");

  a_end_stops: assert property ( // [R09]
    end_drop && prim_s && in_load && !start_ev |=> !load_init_o)
    else $error("primary completion did not end the load");

  a_min_size: assert property ( // [R08]
    main_ff.min_sel |-> total == 15'h1100)
    else $error("minimum size limit not applied");

  a_restart_inhib: assert property ( // [R16]
    rs_pulse && !inh_n_s && !por_s && main_ff.state == ST_LOAD &&
      !(main_ff.por_prev & ~por_s) && !(sw_s & ~main_ff.sw_prev) |=> !sys_reset_o)
    else $error("inhibited restart was acted on");

endmodule

/* File: src/csbl_pkg.sv */
package csbl_pkg;

  // ***********************************
  // Timing
  // ***********************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYSRST_MIN_NS = 400000;
  localparam int unsigned PAUSE_MIN_NS = 2500;
  localparam int unsigned END_DLY_MIN_NS = 1000;
  localparam int unsigned END_HIGH_MIN_NS = 3000;
  // Least times round up to whole cycles
  localparam int unsigned SYSRST_CYC = (SYSRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PAUSE_CYC = (PAUSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned END_DLY_CYC = (END_DLY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned END_HIGH_CYC = (END_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] SYSRST_LAST = 13'(SYSRST_CYC - 1);
  localparam logic [12:0] PAUSE_LAST = 13'(PAUSE_CYC - 1);
  localparam logic [5:0] END_DLY_LAST = 6'(END_DLY_CYC - 1);
  localparam logic [5:0] END_HIGH_LAST = 6'(END_HIGH_CYC - 1);
  localparam logic [5:0] TMR_SAT = 6'h3f;

  // ***********************************
  // Load sizes
  // ***********************************
  localparam logic [14:0] CS_MIN_WORDS = 15'h1000;
  localparam logic [14:0] AT_MIN_WORDS = 15'h0100;
  localparam logic [4:0] CSB_RST = 5'h10;
  localparam logic [2:0] ATB_RST = 3'h4;

  // ***********************************
  // Register map
  // ***********************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int unsigned CTRL_MIN_BIT = 0;
  localparam int unsigned CTRL_CSB_LSB = 4;
  localparam int unsigned CTRL_ATB_LSB = 12;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_LOAD_BIT = 2;
  localparam int unsigned STAT_END_BIT = 3;
  localparam int unsigned STAT_PRIM_BIT = 4;
  localparam int unsigned STAT_MAINT_BIT = 5;
  localparam int unsigned STAT_PEND_BIT = 6;
  localparam logic [2:0] PULSE_RST = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESET = 2'b01,
    ST_PAUSE = 2'b10,
    ST_LOAD = 2'b11
  } csbl_state_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } csbl_bus_s;

  typedef struct packed {
    logic strobe;
    logic at_sel;
    logic [13:0] addr;
    logic [15:0] data;
  } csbl_cswr_s;

  typedef struct packed {
    csbl_state_e state;
    logic [12:0] tmr;
    logic [14:0] cnt;
    logic pend;
    logic run;
    logic [15:0] data;
    csbl_cswr_s wr;
    logic e_arm;
    logic e_out;
    logic e_last;
    logic [5:0] e_tmr;
    logic [5:0] l_tmr;
    logic min_sel;
    logic [4:0] csb;
    logic [2:0] atb;
    logic [31:0] rdata;
    logic por_prev;
    logic sw_prev;
  } csbl_main_s;

  localparam csbl_main_s MAIN_RST = '{
    state: ST_IDLE, tmr: 13'h0000, cnt: 15'h0000, pend: 1'b0, run: 1'b0,
    data: 16'h0000, wr: '{strobe: 1'b0, at_sel: 1'b0, addr: 14'h0000, data: 16'h0000},
    e_arm: 1'b0, e_out: 1'b0, e_last: 1'b0, e_tmr: 6'h00, l_tmr: 6'h00,
    min_sel: 1'b0, csb: CSB_RST, atb: ATB_RST, rdata: 32'h0000_0000,
    por_prev: 1'b0, sw_prev: 1'b0};

endpackage

/* File: src/csbl_pulse.sv */
`timescale 1ns/1ps
module csbl_pulse
  import csbl_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Active-low pulse from a pin
  input wire logic pulse_n_i,
  output logic level_n_o,
  output logic pulse_o
);

  typedef struct packed {
    logic meta;
    logic safe;
    logic prev;
  } csbl_pulse_s;

  csbl_pulse_s pls_ff;
  csbl_pulse_s nxt_pls;

  always_comb begin
    nxt_pls.meta = pulse_n_i;
    nxt_pls.safe = pls_ff.meta;
    nxt_pls.prev = pls_ff.safe;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pls_ff <= PULSE_RST;
    end else begin
      pls_ff <= nxt_pls;
    end
  end

  // One cycle per falling edge, so a long pulse acts once [R20]
  assign pulse_o = pls_ff.prev & ~pls_ff.safe;
  assign level_n_o = pls_ff.safe;

endmodule

/* File: src/csbl_sync.sv */
`timescale 1ns/1ps
module csbl_sync
  import csbl_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rstn_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] safe;
  } csbl_sync_s;

  csbl_sync_s sync_ff;
  csbl_sync_s nxt_sync;

  always_comb begin
    nxt_sync.meta = async_i;
    nxt_sync.safe = sync_ff.meta;
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= nxt_sync;
    end
  end

  assign sync_o = sync_ff.safe;

endmodule
